// ### common/nmi_reset_pkg.sv
// Constants and types shared by the NMI and reset control block
package nmi_reset_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_SOFT_RESET = 16'h1250;
  localparam logic [15:0] OFS_NMI_CTRL   = 16'h1260;
  localparam logic [15:0] OFS_PWR_CTRL   = 16'h1270;
  localparam logic [15:0] OFS_UNLOCK     = 16'h1280;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h1284;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'h1288;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_SOFT_TRIGGER = 0;
  localparam int BIT_DEADMAN      = 25;
  localparam int BIT_WATCHDOG     = 24;
  localparam int BIT_SW_NMI       = 23;
  localparam int BIT_CLOCK_FAIL   = 17;
  localparam int BIT_SLEEP_WAKE   = 16;
  localparam int RELOAD_LSB       = 0;
  localparam int RELOAD_W         = 8;
  localparam int BIT_REG_ACTIVE   = 0;

  // Interrupt status layout
  localparam int IRQ_W            = 3;
  localparam int IRQ_NMI_RAISED   = 0;
  localparam int IRQ_DELAY_START  = 1;
  localparam int IRQ_LOCK_REFUSED = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]       RELOAD_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;
  localparam logic [31:0]      RDATA_RST  = 32'h0000_0000;

  // Unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h1234_5678;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h8765_4321;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    UNLK_LOCKED = 2'b00,
    UNLK_KEY1   = 2'b01,
    UNLK_OPEN   = 2'b10
  } unlockState_t;

  typedef enum logic
  {
    CNT_IDLE = 1'b0,
    CNT_RUN  = 1'b1
  } cntState_t;

endpackage

// ### hw/nmi_reset_counter.sv
// Delayed device reset down-counter
`timescale 1ns/100ps
module nmi_reset_counter
  import nmi_reset_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                load,
  input  wire logic [RELOAD_W-1:0] reload,
  output logic                     expired,
  output logic                     running,
  output logic [RELOAD_W-1:0]      count
);

  typedef struct packed
  {
    cntState_t           st;
    logic [RELOAD_W-1:0] cnt;
    logic                expired;
  } cntRegs_t;

  cntRegs_t s_r;
  cntRegs_t s_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.expired = 1'b0;
    case (s_r.st)
      CNT_IDLE:
      begin
        if (load)
        begin
          if (reload == RELOAD_RST)
          begin
            s_nxt.expired = 1'b1; // R11
          end
          else
          begin
            s_nxt.cnt = reload; // R17
            s_nxt.st  = CNT_RUN;
          end
        end
      end
      CNT_RUN:
      begin
        s_nxt.cnt = s_r.cnt - 8'h01; // R12
        if (s_r.cnt == 8'h01)
        begin
          s_nxt.expired = 1'b1; // R17
          s_nxt.st      = CNT_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = CNT_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= '{st: CNT_IDLE, cnt: RELOAD_RST, expired: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.expired;
  assign running = (s_r.st == CNT_RUN);
  assign count   = s_r.cnt;

endmodule

// ### hw/nmi_reset_control.sv
// NMI sources, software reset and delayed reset control
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
//
// Behaviour
// R01: Software unlocks before writing reset trigger
// R02: Armed trigger: reading register resets device
// R03: Writing one arms reset; zero ignored
// R04: Deadman flag set by timeout or software
// R05: Watchdog flag set by timeout or software
// R06: Software NMI bit raises an NMI
// R07: Clock-fail flag set on monitor failure
// R08: Software clock-fail never switches oscillator
// R09: Sleep watchdog flag raises watchdog NMI
// R10: Eight-bit reload counts system clock cycles
// R11: Zero reload resets without delay
// R12: Counter decrements, resets device at zero
// R13: Only awake watchdog and deadman start counter
// R14: Regulator bit keeps regulator on in Sleep
// R15: Unimplemented bits read zero, ignore writes
// R16: Writable fields are zero after reset
// R17: Counter loads on NMI, one-cycle reset
module nmi_reset_control
  import nmi_reset_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrEn,
  input  wire logic              rdEn,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              watchdogTimeout,
  input  wire logic              deadmanTimeout,
  input  wire logic              clockFailDetect,
  input  wire logic              sleepMode,
  output logic                   nmiRequest,
  output logic                   resetRequest,
  output logic                   clockSwitchRequest,
  output logic                   regulatorSleepActive,
  output logic                   regulatorStandby,
  output logic                   irq
);

  typedef struct packed
  {
    unlockState_t        unlock;
    logic                swArmed;
    logic                swFire;
    logic                deadmanFlag;
    logic                watchdogFlag;
    logic                software_nmi_trigger;
    logic                clockFailFlag;
    logic                sleepWakeFlag;
    logic [RELOAD_W-1:0] reload;
    logic                regActive;
    logic                regStandby;
    logic                clkSwitch;
    logic [IRQ_W-1:0]    irqStatus;
    logic [IRQ_W-1:0]    irqMask;
    logic [DATA_W-1:0]   rdData;
  } ctrlRegs_t;

  ctrlRegs_t s_r;
  ctrlRegs_t s_nxt;

  logic                cntLoad;
  logic                cntExpired;
  logic                cntRunning;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic wrSoft;
  logic wrNmi;
  logic wrPwr;
  logic wrUnlock;
  logic wrStatus;
  logic wrMask;
  logic rdSoft;

  assign wrSoft   = wrEn && (addr == OFS_SOFT_RESET);
  assign wrNmi    = wrEn && (addr == OFS_NMI_CTRL);
  assign wrPwr    = wrEn && (addr == OFS_PWR_CTRL);
  assign wrUnlock = wrEn && (addr == OFS_UNLOCK);
  assign wrStatus = wrEn && (addr == OFS_IRQ_STATUS);
  assign wrMask   = wrEn && (addr == OFS_IRQ_MASK);
  assign rdSoft   = rdEn && (addr == OFS_SOFT_RESET);

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  logic hwWatchdog;
  logic hwSleepWake;
  logic swDeadman;
  logic swWatchdog;
  logic swSoftNmi;
  logic swClockFail;
  logic swSleepWake;
  logic nmiEvent;
  logic lockRefused;

  assign hwWatchdog  = watchdogTimeout && !sleepMode;
  assign hwSleepWake = watchdogTimeout && sleepMode;
  assign swDeadman   = wrNmi && wrData[BIT_DEADMAN];
  assign swWatchdog  = wrNmi && wrData[BIT_WATCHDOG];
  assign swSoftNmi   = wrNmi && wrData[BIT_SW_NMI];
  assign swClockFail = wrNmi && wrData[BIT_CLOCK_FAIL];
  assign swSleepWake = wrNmi && wrData[BIT_SLEEP_WAKE];

  // Only awake watchdog and deadman events start the delay
  assign cntLoad = hwWatchdog || deadmanTimeout || swDeadman || swWatchdog; // R13

  assign nmiEvent = watchdogTimeout || deadmanTimeout || clockFailDetect
                    || swDeadman || swWatchdog || swSoftNmi
                    || swClockFail || swSleepWake;

  assign lockRefused = wrSoft && (s_r.unlock != UNLK_OPEN);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irqSet;

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.swFire = 1'b0;

    // Unlock sequence
    if (wrUnlock)
    begin
      case (s_r.unlock)
        UNLK_LOCKED:
        begin
          s_nxt.unlock = (wrData == UNLOCK_KEY1) ? UNLK_KEY1 : UNLK_LOCKED;
        end
        UNLK_KEY1:
        begin
          s_nxt.unlock = (wrData == UNLOCK_KEY2) ? UNLK_OPEN : UNLK_LOCKED;
        end
        UNLK_OPEN:
        begin
          s_nxt.unlock = UNLK_LOCKED;
        end
        default:
        begin
          s_nxt.unlock = UNLK_LOCKED;
        end
      endcase
    end

    // Software reset arm and fire
    if (wrSoft)
    begin
      s_nxt.unlock = UNLK_LOCKED;
      if ((s_r.unlock == UNLK_OPEN) && wrData[BIT_SOFT_TRIGGER]) // R01 R03
      begin
        s_nxt.swArmed = 1'b1;
      end
    end
    if (rdSoft && s_r.swArmed)
    begin
      s_nxt.swFire  = 1'b1; // R02
      s_nxt.swArmed = 1'b0; // R03
    end

    // NMI control writes, only implemented bits kept
    if (wrNmi)
    begin
      s_nxt.deadmanFlag   = wrData[BIT_DEADMAN]; // R15
      s_nxt.watchdogFlag  = wrData[BIT_WATCHDOG];
      s_nxt.software_nmi_trigger         = wrData[BIT_SW_NMI]; // R06
      s_nxt.clockFailFlag = wrData[BIT_CLOCK_FAIL];
      s_nxt.sleepWakeFlag = wrData[BIT_SLEEP_WAKE];
      s_nxt.reload        = wrData[RELOAD_LSB +: RELOAD_W]; // R10
    end

    // Hardware sets win over software clears
    if (deadmanTimeout)
    begin
      s_nxt.deadmanFlag = 1'b1; // R04
    end
    if (hwWatchdog)
    begin
      s_nxt.watchdogFlag = 1'b1; // R05
    end
    if (clockFailDetect)
    begin
      s_nxt.clockFailFlag = 1'b1; // R07
    end
    if (hwSleepWake)
    begin
      s_nxt.sleepWakeFlag = 1'b1; // R09
    end

    // Oscillator switch only from the monitor itself
    s_nxt.clkSwitch = clockFailDetect; // R08

    // Power control
    if (wrPwr)
    begin
      s_nxt.regActive = wrData[BIT_REG_ACTIVE];
    end
    s_nxt.regStandby = sleepMode && !s_nxt.regActive; // R14

    // Interrupt status, set wins over write-one-clear
    irqSet                   = '0;
    irqSet[IRQ_NMI_RAISED]   = nmiEvent;
    irqSet[IRQ_DELAY_START]  = cntLoad && !cntRunning;
    irqSet[IRQ_LOCK_REFUSED] = lockRefused;
    if (wrStatus)
    begin
      s_nxt.irqStatus = s_r.irqStatus & ~wrData[IRQ_W-1:0];
    end
    s_nxt.irqStatus = s_nxt.irqStatus | irqSet;
    if (wrMask)
    begin
      s_nxt.irqMask = wrData[IRQ_W-1:0];
    end

    // Read data, unmapped and unimplemented bits zero
    s_nxt.rdData = RDATA_RST;
    if (rdEn)
    begin
      case (addr)
        OFS_NMI_CTRL:
        begin
          s_nxt.rdData[BIT_DEADMAN]                = s_r.deadmanFlag; // R15
          s_nxt.rdData[BIT_WATCHDOG]               = s_r.watchdogFlag;
          s_nxt.rdData[BIT_SW_NMI]                 = s_r.software_nmi_trigger;
          s_nxt.rdData[BIT_CLOCK_FAIL]             = s_r.clockFailFlag;
          s_nxt.rdData[BIT_SLEEP_WAKE]             = s_r.sleepWakeFlag;
          s_nxt.rdData[RELOAD_LSB +: RELOAD_W]     = s_r.reload;
        end
        OFS_PWR_CTRL:
        begin
          s_nxt.rdData[BIT_REG_ACTIVE] = s_r.regActive;
        end
        OFS_UNLOCK:
        begin
          s_nxt.rdData[0] = (s_r.unlock == UNLK_OPEN);
        end
        OFS_IRQ_STATUS:
        begin
          s_nxt.rdData[IRQ_W-1:0] = s_r.irqStatus;
        end
        OFS_IRQ_MASK:
        begin
          s_nxt.rdData[IRQ_W-1:0] = s_r.irqMask;
        end
        default:
        begin
          s_nxt.rdData = RDATA_RST;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= '{unlock: UNLK_LOCKED, reload: RELOAD_RST, irqStatus: IRQ_RST,
               irqMask: IRQ_RST, rdData: RDATA_RST, default: 1'b0}; // R16
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Delayed reset counter
  // ---------------------------------------------------------------
  nmi_reset_counter u_counter
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (cntLoad), // R12
    .reload  (s_r.reload),
    .expired (cntExpired),
    .running (cntRunning),
    .count   ()
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdData               = s_r.rdData;
  assign nmiRequest           = s_r.deadmanFlag | s_r.watchdogFlag | s_r.software_nmi_trigger
                                | s_r.clockFailFlag | s_r.sleepWakeFlag;
  assign resetRequest         = s_r.swFire | cntExpired; // R17
  assign clockSwitchRequest   = s_r.clkSwitch;
  assign regulatorSleepActive = s_r.regActive; // R14
  assign regulatorStandby     = s_r.regStandby;
  assign irq                  = |(s_r.irqStatus & s_r.irqMask);

endmodule

// ### verification/nmi_reset_sva.sv
// Assertion checker for the NMI and reset control block
`timescale 1ns/100ps
module nmi_reset_sva
  import nmi_reset_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic              wrEn,
  input wire logic              rdEn,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic              watchdogTimeout,
  input wire logic              deadmanTimeout,
  input wire logic              clockFailDetect,
  input wire logic              sleepMode,
  input wire logic              nmiRequest,
  input wire logic              resetRequest,
  input wire logic              clockSwitchRequest,
  input wire logic              regulatorSleepActive,
  input wire logic              regulatorStandby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence readOf(logic [15:0] a);
    rdEn && addr == a;
  endsequence
  sequence nmiWrite;
    wrEn && addr == OFS_NMI_CTRL;
  endsequence
  sequence zeroCfg;
    nmiWrite and (wrData[7:0] == 8'h00);
  endsequence

  a_reset_pulse: assert property (resetRequest |=> !resetRequest)
    else $error("reset request held past one cycle");
  a_fail_switch: assert property (clockFailDetect |=> clockSwitchRequest && nmiRequest)
    else $error("clock failure did not switch clock and raise nmi");
  a_switch_cause: assert property (clockSwitchRequest |-> $past(clockFailDetect))
    else $error("clock switch without monitor failure");
  a_rd_idle: assert property (!rdEn |=> rdData == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_soft_zero: assert property (readOf(OFS_SOFT_RESET) |=> rdData == 32'h0000_0000)
    else $error("soft reset register read not zero");
  a_unimpl_zero: assert property (readOf(OFS_NMI_CTRL) |=> (rdData & 32'hFC7C_FF00) == 0)
    else $error("unimplemented nmi control bits not zero");
  a_pwr_read: assert property (readOf(OFS_PWR_CTRL) |=>
    rdData == {31'h0000_0000, regulatorSleepActive})
    else $error("power control read wrong");
  a_watchdog_nmi: assert property (watchdogTimeout |=> nmiRequest)
    else $error("watchdog timeout raised no nmi");
  a_deadman_nmi: assert property (deadmanTimeout |=> nmiRequest)
    else $error("deadman timeout raised no nmi");
  a_sw_nmi: assert property (nmiWrite and ((wrData & 32'h0383_0000) != 0) |=> nmiRequest)
    else $error("software flag write raised no nmi");
  a_flags_clear: assert property (nmiWrite and ((wrData & 32'h0383_0000) == 0)
    and !(watchdogTimeout || deadmanTimeout || clockFailDetect) |=> !nmiRequest)
    else $error("nmi held after flags cleared");
  a_standby_follow: assert property (
    regulatorStandby == ($past(sleepMode) && !regulatorSleepActive))
    else $error("regulator standby wrong");
  a_zero_delay: assert property (zeroCfg ##1 !wrEn ##1 deadmanTimeout |=> resetRequest)
    else $error("zero reload did not reset at once");
  a_no_start: assert property (zeroCfg ##[1:8]
    (clockFailDetect || (watchdogTimeout && sleepMode)) |=> !resetRequest)
    else $error("non qualifying nmi started the reset counter");
endmodule

bind nmi_reset_control nmi_reset_sva sva (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .watchdogTimeout(watchdogTimeout), .deadmanTimeout(deadmanTimeout),
  .clockFailDetect(clockFailDetect), .sleepMode(sleepMode), .nmiRequest(nmiRequest),
  .resetRequest(resetRequest), .clockSwitchRequest(clockSwitchRequest),
  .regulatorSleepActive(regulatorSleepActive), .regulatorStandby(regulatorStandby)
);

// ### verification/timer_partner.sv
// Timer event and reset capture model on the far side of the NMI block
`timescale 1ns/100ps
module timer_partner
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] cmd,
  input  wire logic       resetRequest,
  output logic            watchdogTimeout = 1'b0,
  output logic            deadmanTimeout = 1'b0,
  output logic            clockFailDetect = 1'b0,
  output logic [7:0]      resetCount = 8'h00
);
  // One-cycle timeout pulses on command, reset pulses counted
  always @(posedge clk)
  begin
    watchdogTimeout <= cmd[0];
    deadmanTimeout <= cmd[1];
    clockFailDetect <= cmd[2];
    if (sys_rst)
      resetCount <= 8'h00;
    else if (resetRequest)
      resetCount <= resetCount + 8'h01;
  end
endmodule

// ### verification/tb_nmi_reset_control.sv
// Self-checking bench for the NMI and reset control block
`timescale 1ns/100ps
module tb_nmi_reset_control;
  import nmi_reset_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] addr = 16'h0000;
  logic [DATA_W-1:0] wrData = 32'h0000_0000;
  logic              wrEn = 1'b0;
  logic              rdEn = 1'b0;
  logic              sleepMode = 1'b0;
  logic [2:0]        cmd = 3'h0;
  logic [DATA_W-1:0] rdData;
  logic              watchdogTimeout, deadmanTimeout, clockFailDetect, nmiRequest;
  logic              resetRequest, clockSwitchRequest, regulatorSleepActive;
  logic              regulatorStandby, irq;
  logic [7:0]        resetCount, r0;
  logic [31:0]       d, q;
  logic [15:0]       regs [7] = '{OFS_SOFT_RESET, OFS_NMI_CTRL, OFS_PWR_CTRL, OFS_UNLOCK,
                                  OFS_IRQ_STATUS, OFS_IRQ_MASK, 16'h1000};
  int                seed = 32'h6e91_7de4;
  int                n_fail = 0;
  int                n_checks = 0;

  initial
    forever #50 clk = ~clk;

  nmi_reset_control dut (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .watchdogTimeout(watchdogTimeout), .deadmanTimeout(deadmanTimeout),
    .clockFailDetect(clockFailDetect), .sleepMode(sleepMode), .nmiRequest(nmiRequest),
    .resetRequest(resetRequest), .clockSwitchRequest(clockSwitchRequest),
    .regulatorSleepActive(regulatorSleepActive), .regulatorStandby(regulatorStandby),
    .irq(irq));
  timer_partner far (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .resetRequest(resetRequest),
    .watchdogTimeout(watchdogTimeout), .deadmanTimeout(deadmanTimeout),
    .clockFailDetect(clockFailDetect), .resetCount(resetCount));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 v = rdData;
    @(posedge clk);
  endtask

  function automatic int exp_lat(input int src, input int n);
    return n + ((src == 2) ? 1 : 2);
  endfunction

  // Source 0 watchdog, 1 deadman, 2 software deadman write
  task automatic fire(input int src, input logic [7:0] n);
    int c;
    wr(OFS_NMI_CTRL, {24'h00_0000, n});
    if (src == 2)
    begin
      wrData <= 32'h0200_0000 | n;
      wrEn <= 1'b1;
    end
    else
      cmd <= 3'(src + 1);
    c = 0;
    do
    begin
      @(posedge clk);
      wrEn <= 1'b0;
      cmd <= 3'h0;
      #1 c++;
    end
    while (resetRequest !== 1'b1 && c < 400);
    chk(c, exp_lat(src, n));
    if (c >= 400)
      report_and_stop();
    @(posedge clk);
    rd(OFS_NMI_CTRL, q);
    chk(q & 32'h0300_0000, (src == 0) ? 32'h0100_0000 : 32'h0200_0000);
    wr(OFS_NMI_CTRL, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (regs[i])
    begin
      rd(regs[i], q);
      chk(q, 32'h0000_0000);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++)
    begin
      d = ((i == 0) ? 32'hFFFF_FFFF : $random(seed)) & 32'hFCFF_FFFF;
      wr(OFS_NMI_CTRL, d);
      rd(OFS_NMI_CTRL, q);
      chk(q, d & 32'h0083_00FF);
      chk(nmiRequest, |(d & 32'h0083_0000));
    end
    wr(OFS_NMI_CTRL, 32'h0000_0000);
    chk(nmiRequest, 1'b0);
    $display("test nmi control done");
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      d[0] = i[1];
      sleepMode <= i[0];
      wr(OFS_PWR_CTRL, d);
      rd(OFS_PWR_CTRL, q);
      chk(q, d & 32'h0000_0001);
      chk(regulatorStandby, i[0] & ~d[0]);
      chk(regulatorSleepActive, d[0]);
    end
    sleepMode <= 1'b0;
    $display("test power control done");
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_SOFT_RESET, 32'h0000_0001);
    rd(OFS_SOFT_RESET, q);
    repeat (3) @(posedge clk);
    chk(resetCount, 8'h00);
    rd(OFS_IRQ_STATUS, q);
    chk(q[2], 1'b1);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    chk(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h0000_0004);
    chk(irq, 1'b0);
    $display("test locked trigger done");
    for (int v = 0; v < 2; v++)
    begin
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_UNLOCK, UNLOCK_KEY2);
      wr(OFS_SOFT_RESET, 32'(v));
      rd(OFS_SOFT_RESET, q);
      @(posedge clk);
      #1 chk(resetCount, 8'(v));
    end
    $display("test soft reset done");
    for (int i = 0; i < 9; i++)
      fire(i % 3, (i < 3) ? 8'h00 : (i < 6) ? 8'hFF : 8'($random(seed)));
    $display("test reset counter done");
    r0 = resetCount;
    wr(OFS_NMI_CTRL, 32'h0000_0000);
    sleepMode <= 1'b1;
    cmd <= 3'h1;
    @(posedge clk);
    cmd <= 3'h4;
    @(posedge clk);
    cmd <= 3'h0;
    sleepMode <= 1'b0;
    @(posedge clk);
    #1 chk(clockSwitchRequest, 1'b1);
    repeat (300) @(posedge clk);
    chk(resetCount, r0);
    rd(OFS_NMI_CTRL, q);
    chk(q, 32'h0003_0000);
    $display("test sleep and clock fail done");
    report_and_stop();
  end
endmodule
